// >>> pkg/esc_pkg.sv
// Package for the error-correcting SRAM bus controller: address map, lane layout,
// transfer encodings, check-code matrix and the carried structs.
// Assumes an AHB-Lite slave context at 100 MHz with one clock and one reset.
package esc_pkg;
  localparam int unsigned RAM_WORDS  = 4096;
  localparam int unsigned WORD_AW    = 12;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned CHK_W      = 7;
  localparam logic [31:0] MAIN_BASE  = 32'h2000_0000;
  localparam logic [31:0] SIDE_BASE  = 32'h2001_0000;
  localparam logic [16:0] SIDE_SEL   = 17'h1_0000;
  localparam logic [1:0]  HT_NONSEQ  = 2'h2;
  localparam logic [2:0]  HS_WORD    = 3'h2;
  localparam logic [2:0]  HS_HALF    = 3'h1;
  localparam bit          PIPE_RST   = 1'b1;

  typedef struct packed {
    logic        write;
    logic        side;
    logic [2:0]  size;
    logic [16:0] addr;
  } esc_req_t;

  typedef struct packed {
    logic        single;
    logic        double;
    logic [31:0] addr;
  } esc_err_t;

  // Shared SECDED matrix: Hamming positions 1..38 with overall parity
  function automatic logic [6:0] esc_chk(input logic [31:0] d);
    logic [5:0] s;
    logic [5:0] pos;
    logic       p;
    int         k;
    int         j;
    s = '0;
    k = 0;
    for (j = 1; j < 39; j++) begin
      if ((j & (j - 1)) != 0) begin
        pos = 6'(j);
        if (d[k]) s = s ^ pos;
        k++;
      end
    end
    p = ^d ^ ^s;
    return {p, s};
  endfunction : esc_chk

  function automatic logic [5:0] esc_pos(input int unsigned bitIdx);
    int k;
    int j;
    logic [5:0] r;
    r = '0;
    k = 0;
    for (j = 1; j < 39; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (k == int'(bitIdx)) r = 6'(j);
        k++;
      end
    end
    return r;
  endfunction : esc_pos
endpackage : esc_pkg

// >>> rtl/esc_sram_ctrl.sv
// Error-correcting SRAM controller: one AHB-Lite slave with its own two RAMs.
// Assumes bus inputs synchronous to mclk; counters and mode bits live outside.
`timescale 1ns/1ps
module esc_sram_ctrl
  import esc_pkg::*;
#(
  parameter int unsigned WORDS = esc_pkg::RAM_WORDS
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rstn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Control from the system register block
  input  wire logic                correction_on_mode,
  input  wire logic                read_pipeline_en,
  // Error reporting to the system register block
  output esc_pkg::esc_err_t        errOut
);
  import esc_pkg::*;

  // Gray path: idle, piped read, error tail
  typedef enum logic [1:0] {
    ESC_IDLE = 2'b00, ESC_RD = 2'b01, ESC_ERR = 2'b11
  } esc_state_t;

  logic [39:0] ramLow  [WORDS];
  logic [39:0] ramHigh [WORDS];

  esc_state_t  state_q, state_d;
  esc_req_t    req_q;
  logic        first_q;
  logic        pipe_q;
  logic [39:0] dout_q;
  logic [31:0] hrdata_q;
  logic        hready_q, hresp_q;
  esc_err_t    err_q;

  // Address phase decode
  wire        take    = hsel & hready & htrans[1];
  wire        isSide  = (haddr[16:0] & SIDE_SEL) != 17'h0_0000;
  wire        narrow  = hsize != HS_WORD;
  wire        waitReq = ~hwrite | (correction_on_mode & narrow & ~isSide);

  // Main words: RAM by bit 14. Side bytes: RAM by bit 12, lane bits on top of the location
  function automatic logic [12:0] esc_loc(input esc_req_t r);
    if (r.side) return {r.addr[12], r.addr[1], r.addr[0], r.addr[11:2]};
    return {r.addr[14], r.addr[13:2]};
  endfunction : esc_loc

  wire esc_req_t cur = '{write: hwrite, side: isSide, size: hsize, addr: haddr[16:0]};
  wire [12:0] memLoc = esc_loc(req_q);
  wire [39:0] rdRaw  = memLoc[12] ? ramHigh[memLoc[11:0]] : ramLow[memLoc[11:0]];

  // Data phase qualifiers; first_q marks the first data-phase cycle only
  wire narrowQ  = req_q.size != HS_WORD;
  wire rdFirst  = first_q & ~req_q.write;
  wire rmwFirst = first_q & req_q.write & correction_on_mode & narrowQ & ~req_q.side;
  wire rdDone   = (rdFirst & ~pipe_q) | (state_q == ESC_RD);
  wire chkNow   = rdDone | rmwFirst;

  // Unpiped accesses check the array output, piped reads the registered copy
  wire [39:0] ckIn  = (state_q == ESC_RD) ? dout_q : rdRaw;
  wire [6:0]  chkRd = esc_chk(ckIn[31:0]);
  wire [6:0]  syn   = {^ckIn[38:0], chkRd[5:0] ^ ckIn[37:32]};
  logic [31:0] fixed;
  always_comb begin
    fixed = ckIn[31:0];
    for (int i = 0; i < 32; i++) begin
      if (syn[6] && syn[5:0] == esc_pos(i)) fixed[i] = ~fixed[i];
    end
  end

  wire errOne = correction_on_mode & ~req_q.side & syn[6];
  wire errTwo = correction_on_mode & ~req_q.side & ~syn[6] & (syn[5:0] != 6'h00);
  wire [31:0] rdWord = correction_on_mode ? fixed : ckIn[31:0];
  wire [7:0]  laneFour = ckIn[39:32];
  wire [31:0] rdBus = req_q.side ? {4{laneFour}} : rdWord;

  // Byte-lane merge for narrow writes
  logic [31:0] merged;
  logic [3:0]  be;
  always_comb begin
    be = 4'h1 << req_q.addr[1:0];
    if (req_q.size == HS_HALF) be = req_q.addr[1] ? 4'hC : 4'h3;
    if (req_q.size == HS_WORD) be = 4'hF;
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = be[b] ? hwdata[8*b +: 8] : rdWord[8*b +: 8];
    end
  end

  // Write path; a double error in the read half suppresses the write-back
  wire fullWr = first_q & req_q.write & ~req_q.side & (~correction_on_mode | ~narrowQ);
  wire sideWr = first_q & req_q.write & req_q.side & ~correction_on_mode;
  wire rmwWr  = rmwFirst & ~errTwo;
  wire [7:0] sideByte = hwdata[8*req_q.addr[1:0] +: 8];
  wire [39:0] wrMain = {1'b0, esc_chk(hwdata), hwdata};
  wire [39:0] wrRmw  = {1'b0, esc_chk(merged), merged};

  always_ff @(posedge mclk) begin
    if (fullWr) begin
      for (int b = 0; b < 4; b++) begin
        if (be[b]) begin
          if (memLoc[12]) ramHigh[memLoc[11:0]][8*b +: 8] <= wrMain[8*b +: 8];
          else ramLow[memLoc[11:0]][8*b +: 8] <= wrMain[8*b +: 8];
        end
      end
      // Raw mode leaves lane four to the side region
      if (correction_on_mode) begin
        if (memLoc[12]) ramHigh[memLoc[11:0]][39:32] <= wrMain[39:32];
        else ramLow[memLoc[11:0]][39:32] <= wrMain[39:32];
      end
    end else if (rmwWr) begin
      if (memLoc[12]) ramHigh[memLoc[11:0]] <= wrRmw;
      else ramLow[memLoc[11:0]] <= wrRmw;
    end else if (sideWr) begin
      if (memLoc[12]) ramHigh[memLoc[11:0]][39:32] <= sideByte;
      else ramLow[memLoc[11:0]][39:32] <= sideByte;
    end
    dout_q <= rdRaw;
  end

  // Controller state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ESC_IDLE: begin
        if (rdFirst && pipe_q) state_d = ESC_RD;
        else if (chkNow && errTwo) state_d = ESC_ERR;
      end
      ESC_RD:   state_d = errTwo ? ESC_ERR : ESC_IDLE;
      ESC_ERR:  state_d = ESC_IDLE;
      default:  state_d = ESC_IDLE;
    endcase
  end

  // Reads and narrow corrected writes wait from the address phase on
  wire hreadyD = ~((take & waitReq) | (state_d == ESC_RD) |
                   (state_d == ESC_ERR & state_q != ESC_ERR));
  wire hrespD  = (state_d == ESC_ERR) | (state_q == ESC_ERR);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ESC_IDLE;
      req_q     <= '0;
      first_q   <= 1'b0;
      pipe_q    <= PIPE_RST;
      hrdata_q  <= '0;
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
      err_q     <= '0;
    end else begin
      state_q  <= state_d;
      pipe_q   <= read_pipeline_en;
      first_q  <= take;
      if (take) req_q <= cur;
      hready_q <= hreadyD;
      hresp_q  <= hrespD;
      if (rdDone) hrdata_q <= rdBus;
      err_q.single <= chkNow & errOne;
      err_q.double <= chkNow & errTwo;
      if (chkNow && (errOne || errTwo)) begin
        err_q.addr <= MAIN_BASE | {15'h0000, req_q.addr};
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = hresp_q;
  assign errOut    = err_q;
endmodule : esc_sram_ctrl

// >>> verif/esc_sram_ctrl_asserts.sv
// Port checker for the SRAM controller.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
module esc_sram_ctrl_asserts
  import esc_pkg::*;
#(parameter int unsigned WORDS = 4096) (
  input wire logic mclk, rstn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic correction_on_mode, read_pipeline_en,
  input esc_pkg::esc_err_t errOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire take = hsel && hready && htrans[1] && hreadyout;
  wire rdTake = take && !hwrite;
  a_reset_idle: assert property ($rose(rstn) |-> hreadyout && !hresp && errOut == '0) else $error("busy after reset");
  a_word_nowait: assert property (take && hwrite && hsize == HS_WORD |=> hreadyout) else $error("word write waited");
  a_raw_nowait: assert property (take && hwrite && !correction_on_mode |=> hreadyout) else $error("raw write waited");
  a_rmw_one_wait: assert property (take && hwrite && hsize != HS_WORD && correction_on_mode
    |=> !hreadyout ##1 (hreadyout || hresp)) else $error("narrow write wait wrong");
  a_pipe_read: assert property (rdTake && read_pipeline_en |=> !hreadyout [*2] ##1 (hreadyout || hresp))
    else $error("piped read wait wrong");
  a_flat_read: assert property (rdTake && !read_pipeline_en |=> !hreadyout ##1 (hreadyout || hresp))
    else $error("flat read wait wrong");
  a_err_shape: assert property ($rose(hresp) |-> !hreadyout ##1 (hresp && hreadyout)) else $error("error response shape");
  a_flag_pulse: assert property (errOut.single || errOut.double |=> !errOut.single && !errOut.double)
    else $error("error flag not a pulse");
  a_raw_quiet: assert property (!correction_on_mode && !$past(correction_on_mode, 3) |-> !errOut.single && !errOut.double)
    else $error("flag in raw mode");
  a_double_err: assert property (errOut.double |-> hresp) else $error("double error without ERROR");
  a_single_okay: assert property (errOut.single |-> !hresp) else $error("single error gave ERROR");
  c_read: cover property (rdTake);
  c_err: cover property ($rose(hresp));
  c_single: cover property (errOut.single);
endmodule : esc_sram_ctrl_asserts
bind esc_sram_ctrl esc_sram_ctrl_asserts #(.WORDS(WORDS)) u_chk (.mclk, .rstn, .hsel, .hwrite, .hready,
  .hreadyout, .hresp, .htrans, .hsize, .correction_on_mode, .read_pipeline_en, .errOut);

// >>> verif/esc_ahb_master.sv
// Bus master model: one AHB-Lite transfer at a time.
// Assumes a lone slave, so hready follows hreadyout.
`timescale 1ns/1ps
module esc_ahb_master
  import esc_pkg::*;
(
  input wire logic mclk, hreadyout, hresp,
  input wire logic [31:0] hrdata,
  output logic hsel, hwrite,
  output logic [31:0] haddr, hwdata,
  output logic [1:0] htrans,
  output logic [2:0] hsize
);
  initial {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
  // Bounded wait so a stuck slave cannot hang the bench
  // Ready, data and response are looked at mid-cycle, where they have settled
  task automatic waitRdy(output logic [31:0] rdv, output logic rspv);
    int n;
    logic rdy;
    n = 0;
    do begin
      @(negedge mclk);
      rdy = hreadyout;
      rdv = hrdata;
      rspv = hresp;
      @(posedge mclk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
  endtask : waitRdy
  task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd,
                      output logic [31:0] rd, output logic rsp);
    @(posedge mclk);
    {hsel, hwrite, haddr, htrans, hsize} <= {1'b1, w, a, HT_NONSEQ, sz};
    waitRdy(rd, rsp);
    // Released address is inverted, never left looking valid
    {hsel, htrans, haddr} <= {1'b0, 2'h0, ~a};
    hwdata <= wd;
    waitRdy(rd, rsp);
    hwdata <= ~wd;
  endtask : xfer
endmodule : esc_ahb_master

// >>> verif/esc_sram_ctrl_tb_top.sv
// Directed bench for the SRAM controller.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module esc_sram_ctrl_tb_top;
  import esc_pkg::*;
  logic mclk = 0, rstn = 0, corrOn = 1, pipeEn = 1, hsel, hwrite, hreadyout, hresp, rsp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  esc_err_t errOut;
  int n_fail = 0, n_checks = 0, nSingle = 0, nDouble = 0, cyc = 0;
  always #5 mclk = ~mclk;
  esc_ahb_master mst (.mclk, .hreadyout, .hresp, .hrdata, .hsel, .hwrite, .haddr, .hwdata, .htrans, .hsize);
  esc_sram_ctrl #(.WORDS(RAM_WORDS)) DUT (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .correction_on_mode(corrOn), .read_pipeline_en(pipeEn), .errOut);
  // Flag pulses are counted mid-cycle so the count is settled when a task returns
  always @(negedge mclk) begin
    cyc++;
    nSingle += int'(errOut.single === 1'b1);
    nDouble += int'(errOut.double === 1'b1);
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
    mst.xfer(1'b1, a, sz, wd, rd, rsp);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] exp, input logic er);
    mst.xfer(1'b0, a, sz, 32'h0000_0000, rd, rsp);
    if (!er) check(rd, exp);
    check({31'h0, rsp}, {31'h0, er});
  endtask : rdc
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    wr(MAIN_BASE, HS_WORD, 32'h1234_5678);
    rdc(MAIN_BASE, HS_WORD, 32'h1234_5678, 1'b0);
    wr(MAIN_BASE + 32'h0000_4000, HS_WORD, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) wr(MAIN_BASE + 32'h0000_4000 + i, 3'h0, {4{8'(8'hA0 + i)}});
    rdc(MAIN_BASE + 32'h0000_4000, HS_WORD, 32'hA3A2_A1A0, 1'b0);
    wr(MAIN_BASE + 32'h0000_4002, HS_HALF, 32'hBEEF_0000);
    pipeEn <= 1'b0;
    rdc(MAIN_BASE + 32'h0000_4000, HS_WORD, 32'hBEEF_A1A0, 1'b0);
    pipeEn <= 1'b1;
    corrOn <= 1'b0;
    wr(SIDE_BASE + 32'h0000_0003, 3'h0, 32'h5A00_0000);
    rdc(SIDE_BASE + 32'h0000_0003, 3'h0, 32'h5A5A_5A5A, 1'b0);
    rdc(MAIN_BASE, HS_WORD, 32'h1234_5678, 1'b0);
    // Raw mode leaves check bits alone, so a raw byte write plants a fault
    wr(MAIN_BASE, 3'h0, 32'h0000_0079);
    corrOn <= 1'b1;
    rdc(MAIN_BASE, HS_WORD, 32'h1234_5678, 1'b0);
    check(32'(nSingle), 32'h0000_0001);
    corrOn <= 1'b0;
    wr(MAIN_BASE, 3'h0, 32'h0000_007B);
    corrOn <= 1'b1;
    rdc(MAIN_BASE, HS_WORD, 32'h0000_0000, 1'b1);
    check(32'(nDouble), 32'h0000_0001);
    check(errOut.addr, MAIN_BASE);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    check(errOut.addr, 32'h0000_0000);
    rstn <= 1'b1;
    rdc(MAIN_BASE + 32'h0000_4000, HS_WORD, 32'hBEEF_A1A0, 1'b0);
    summarize();
  end
endmodule : esc_sram_ctrl_tb_top
